// *** dsc_instruction_decode_timing.sv ***
`timescale 1ns/1ns
`include "dsc_decode_defines.svh"
module dsc_instruction_decode_timing
    import dsc_decode_pkg::*;
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire apb_req_t           apb_req,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Program memory stream
    input  wire logic               pm_valid,
    input  wire logic [`WORD_W-1:0] pm_word,
    output logic                    pm_ready,
    // Execution side
    input  wire logic               cond_true,
    output logic                    dec_valid,
    output dec_t                    dec_q,
    output logic [1:0]              dec_cycles,
    output logic                    nop_slot
);
    state_t             state_ff;
    state_t             nxt_state;
    logic [`WORD_W-1:0] first_ff;
    logic [1:0]         hold_ff;
    logic               ctrl_en_ff;
    logic [31:0]        icnt_ff;
    logic [31:0]        ccnt_ff;
    logic [3:0]         err_ff;
    logic [31:0]        prdata_ff;
    logic [`WORD_W-1:0] ext_src;
    logic [`WORD_W-1:0] main_src;
    dec_t               dec_c;
    logic               take;
    logic               issue;
    logic [1:0]         issue_cyc;
    logic [1:0]         issue_words;
    logic               apb_wr;
    logic               apb_rd_setup;
    logic               apb_access;
    logic               mapped;
    logic               clr_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Field extraction
    assign main_src = (state_ff == ST_FETCH) ? pm_word : first_ff;
    assign ext_src  = pm_word;

    dsc_field_extract u_extract (
        .word     (main_src),
        .ext_word (ext_src),
        .dec      (dec_c)
    );

    // Cycle count of a single-word instruction
    function automatic logic [1:0] cycles_of(input dec_t d, input logic c);
        logic [1:0] n;
        n = `CYC_ONE;
        if (d.cls == CLS_MOVD) begin
            n = `CYC_TWO;
        end else if (d.cls == CLS_CTRL) begin
            unique case (d.opcode)
                `OP_REL_BR, `OP_CALL_IND, `OP_GOTO_IND,
                `OP_TBL_RD, `OP_TBL_WR: n = `CYC_TWO;
                `OP_COMP_BR, `OP_RETURN, `OP_INT_RET:
                    n = `CYC_THREE;
                `OP_COND_BR: n = c ? `CYC_TWO : `CYC_ONE;
                default: n = `CYC_ONE;
            endcase
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign take = pm_valid && pm_ready;

    always_comb begin
        pm_ready = 1'b0;
        unique case (state_ff)
            ST_FETCH:                    pm_ready = ctrl_en_ff;
            ST_EXT, ST_SKIP, ST_SKIP_EXT: pm_ready = 1'b1;
            default:                     pm_ready = 1'b0;
        endcase
    end

    always_comb begin
        nxt_state   = state_ff;
        issue       = 1'b0;
        issue_cyc   = `CYC_ONE;
        issue_words = `CYC_ONE;
        unique case (state_ff)
            ST_FETCH: begin
                if (take) begin
                    if (dec_c.two_word) begin
                        nxt_state = ST_EXT;
                    end else if (dec_c.opcode == `OP_SKIP && cond_true) begin
                        nxt_state = ST_SKIP;
                    end else begin
                        issue     = 1'b1;
                        issue_cyc = cycles_of(dec_c, cond_true);
                    end
                end
            end
            ST_EXT: begin
                if (take) begin
                    issue       = 1'b1;
                    issue_cyc   = `CYC_TWO;
                    issue_words = `CYC_TWO;
                    nxt_state   = ST_FETCH;
                end
            end
            ST_SKIP: begin
                if (take) begin
                    if (is_two_word(pm_word[`F_OPC])) begin
                        nxt_state = ST_SKIP_EXT;
                    end else begin
                        issue       = 1'b1;
                        issue_cyc   = `CYC_TWO;
                        issue_words = `CYC_TWO;
                        nxt_state   = ST_FETCH;
                    end
                end
            end
            ST_SKIP_EXT: begin
                if (take) begin
                    issue       = 1'b1;
                    issue_cyc   = `CYC_THREE;
                    issue_words = `CYC_THREE;
                    nxt_state   = ST_FETCH;
                end
            end
            ST_HOLD: begin
                if (hold_ff == `CYC_ONE) begin
                    nxt_state = ST_FETCH;
                end
            end
            default: nxt_state = ST_FETCH;
        endcase
        if (issue && issue_cyc != issue_words) begin
            nxt_state = ST_HOLD;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_FETCH;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // First word kept while its extension or a skipped word arrives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_ff <= '0;
        end else if (state_ff == ST_FETCH && take) begin
            first_ff <= pm_word;
        end
    end

    // Extra cycles executed as no-operation slots
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ff <= '0;
        end else if (issue) begin
            hold_ff <= issue_cyc - issue_words;
        end else if (state_ff == ST_HOLD) begin
            hold_ff <= hold_ff - `CYC_ONE;
        end
    end

    assign nop_slot = (state_ff == ST_HOLD);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_valid  <= 1'b0;
            dec_q      <= '0;
            dec_cycles <= '0;
        end else begin
            dec_valid <= issue;
            if (issue) begin
                dec_q      <= dec_c;
                dec_cycles <= issue_cyc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Statistics and sticky error flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icnt_ff <= '0;
            ccnt_ff <= '0;
        end else if (clr_cnt) begin
            icnt_ff <= '0;
            ccnt_ff <= '0;
        end else if (issue) begin
            icnt_ff <= icnt_ff + 32'h0000_0001;
            ccnt_ff <= ccnt_ff + 32'(issue_cyc);
        end
    end

    // A new error in the clearing cycle stays set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ff <= '0;
        end else begin
            err_ff <= (err_ff & ~((apb_wr && apb_req.paddr == `A_ERR) ?
                       apb_req.pwdata[3:0] : 4'h0)) |
                      (issue ? dec_c.errs : 4'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign apb_access   = apb_req.psel && apb_req.penable;
    assign apb_wr       = apb_access && apb_req.pwrite;
    assign apb_rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign clr_cnt      = apb_wr && apb_req.paddr == `A_CTRL &&
                          apb_req.pwdata[`C_CLR];
    assign pready       = 1'b1;
    assign pslverr      = apb_access && !mapped;
    assign prdata       = prdata_ff;

    always_comb begin
        unique case (apb_req.paddr)
            `A_CTRL, `A_STATUS, `A_ICNT, `A_CCNT, `A_ERR, `A_LAST:
                mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_ff <= 1'b0;
        end else if (apb_wr && apb_req.paddr == `A_CTRL) begin
            ctrl_en_ff <= apb_req.pwdata[`C_EN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (apb_rd_setup) begin
            unique case (apb_req.paddr)
                `A_CTRL:   prdata_ff <= 32'(ctrl_en_ff);
                `A_STATUS: prdata_ff <= 32'({hold_ff, state_ff});
                `A_ICNT:   prdata_ff <= icnt_ff;
                `A_CCNT:   prdata_ff <= ccnt_ff;
                `A_ERR:    prdata_ff <= 32'(err_ff);
                `A_LAST:   prdata_ff <= 32'({dec_q.cls, dec_q.two_word,
                                             dec_cycles, dec_q.opcode});
                default:   prdata_ff <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_ext_taken;
        state_ff == ST_EXT && take;
    endsequence

    sequence s_one_nop;
        nop_slot ##1 !nop_slot;
    endsequence

    property p_ext_not_dispatched;
        s_ext_taken |=> dec_valid && dec_q.two_word && !nop_slot;
    endproperty
    a_ext_not_dispatched: assert property (p_ext_not_dispatched)
        else $error("extension word not merged into its instruction");

    property p_two_word_cycles;
        dec_valid && dec_q.two_word |-> dec_cycles == `CYC_TWO;
    endproperty
    a_two_word_cycles: assert property (p_two_word_cycles)
        else $error("two-word instruction not two cycles");

    property p_single_extra_nop;
        $past(state_ff) == ST_FETCH && dec_valid &&
            dec_cycles == `CYC_TWO |-> s_one_nop;
    endproperty
    a_single_extra_nop: assert property (p_single_extra_nop)
        else $error("two-cycle instruction lacks one nop slot");

    property p_skip_two;
        state_ff == ST_SKIP && take && !is_two_word(pm_word[`F_OPC])
            |=> dec_valid && dec_cycles == `CYC_TWO ##1 !nop_slot;
    endproperty
    a_skip_two: assert property (p_skip_two)
        else $error("skip over one word not two cycles");

    property p_skip_three;
        state_ff == ST_SKIP && take && is_two_word(pm_word[`F_OPC])
            ##1 take |=> dec_valid && dec_cycles == `CYC_THREE;
    endproperty
    a_skip_three: assert property (p_skip_three)
        else $error("skip over two words not three cycles");

    property p_lone_ext_nop;
        state_ff == ST_FETCH && take && pm_word[`F_OPC] == `OP_NOP
            |=> dec_valid && dec_cycles == `CYC_ONE &&
                dec_q.mcu_flags == '0 && dec_q.dsp_flags == '0;
    endproperty
    a_lone_ext_nop: assert property (p_lone_ext_nop)
        else $error("lone extension word has side effects");

    property p_addr_lsb;
        dec_valid && dec_q.two_word |-> !dec_q.prog_addr[0];
    endproperty
    a_addr_lsb: assert property (p_addr_lsb)
        else $error("program address literal has odd LSB");

    property p_word_default;
        dec_valid && dec_q.cls == CLS_WORKING_REG_ZERO && !dec_q.opcode[`OPB_BYTE]
            |-> dec_q.size == SZ_WORD;
    endproperty
    a_word_default: assert property (p_word_default)
        else $error("word size not taken as default");

    property p_movd_two;
        dec_valid && dec_q.cls == CLS_MOVD
            |-> dec_cycles == `CYC_TWO ##0 s_one_nop;
    endproperty
    a_movd_two: assert property (p_movd_two)
        else $error("double-word move not two cycles");
endmodule // dsc_instruction_decode_timing

// *** dsc_decode_defines.svh ***
`ifndef DSC_DECODE_DEFINES_SVH
`define DSC_DECODE_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////
// Instruction word layout
`define WORD_W      24
`define F_OPC       23:16
`define F_CLS       23:21
`define F_BASE      15:12
`define F_SMODE     11:10
`define F_SREG      9:6
`define F_DMODE     5:4
`define F_DREG      3:0
`define F_FADDR     12:0
`define F_FDEST     13
`define F_BITSEL    3:0
`define F_BITREG    7:4
`define F_BITMODE   9:8
`define F_BITF      15:4
`define F_LIT       13:4
`define F_ACC       15
`define F_MPAIR     14:12
`define F_XPF       11:8
`define F_YPF       7:4
`define F_WB        1:0
`define F_EXTADDR   6:0
`define F_ADDRHI    15:1
`define OPB_BYTE    0
`define OPB_SIGNED  1
`define OPB_FILE    0
`define OPB_INDIR   1
`define BYTE_LIT_MAX 10'h0FF
`define EXT_HI_ZERO 8'h00
////////////////////////////////////////////////////////////////////////////
// Control opcodes
`define OP_NOP       8'h00
`define OP_REL_BR    8'h01
`define OP_CALL2     8'h02
`define OP_COMP_BR   8'h03
`define OP_GOTO2     8'h04
`define OP_CALL_IND  8'h05
`define OP_GOTO_IND  8'h06
`define OP_TBL_RD    8'h07
`define OP_LOOP2     8'h08
`define OP_TBL_WR    8'h09
`define OP_RETURN    8'h0A
`define OP_INT_RET   8'h0B
`define OP_SKIP      8'h0C
`define OP_COND_BR   8'h0D
////////////////////////////////////////////////////////////////////////////
// Write-back modes, flags, cycle counts
`define WB_NONE      2'h0
`define WB_W13       2'h1
`define WB_W13_INC   2'h2
`define WB_RSVD      2'h3
`define MCU_ALL      5'h1F
`define MCU_Z        5'h01
`define DSP_ALL      4'hF
`define CYC_ONE      2'h1
`define CYC_TWO      2'h2
`define CYC_THREE    2'h3
////////////////////////////////////////////////////////////////////////////
// Register map
`define A_CTRL       8'h00
`define A_STATUS     8'h04
`define A_ICNT       8'h08
`define A_CCNT       8'h0C
`define A_ERR        8'h10
`define A_LAST       8'h14
`define C_EN         0
`define C_CLR        1
`define E_LIT        0
`define E_ADDR       1
`define E_EXT        2
`define E_WB         3
`endif

// *** dsc_decode_pkg.sv ***
`include "dsc_decode_defines.svh"
package dsc_decode_pkg;
    typedef enum logic [2:0] {
        CLS_CTRL = 3'b000, CLS_WORKING_REG_ZERO = 3'b001, CLS_FILE = 3'b010,
        CLS_BIT  = 3'b011, CLS_LIT  = 3'b100, CLS_MAC  = 3'b101,
        CLS_DSP  = 3'b110, CLS_MOVD = 3'b111
    } class_t;

    typedef enum logic [1:0] {
        SZ_WORD = 2'b00, SZ_BYTE = 2'b01, SZ_DWORD = 2'b10
    } size_t;

    typedef enum logic [2:0] {
        ST_FETCH = 3'b000, ST_EXT = 3'b001, ST_SKIP = 3'b010,
        ST_SKIP_EXT = 3'b011, ST_HOLD = 3'b100
    } state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        class_t      cls;
        logic [7:0]  opcode;
        size_t       size;
        logic        two_word;
        logic [3:0]  base_operand_reg;
        logic [1:0]  src_mode;
        logic [3:0]  source_operand_reg;
        logic [1:0]  dst_mode;
        logic [3:0]  dest_operand_reg;
        logic [12:0] f_addr;
        logic        f_to_working_reg_zero;
        logic [3:0]  bit_sel;
        logic        bit_indirect;
        logic        bit_on_file;
        logic [15:0] lit;
        logic        acc_b;
        logic [2:0]  mult_pair;
        logic [3:0]  x_prefetch;
        logic [3:0]  y_prefetch;
        logic [1:0]  wb_mode;
        logic [22:0] prog_addr;
        logic [4:0]  mcu_flags;
        logic [3:0]  dsp_flags;
        logic [3:0]  errs;
    } dec_t;

    function automatic logic is_two_word(input logic [7:0] op);
        return (op == `OP_CALL2) || (op == `OP_GOTO2) ||
               (op == `OP_LOOP2);
    endfunction
endpackage

// *** dsc_field_extract.sv ***
`timescale 1ns/1ns
`include "dsc_decode_defines.svh"
module dsc_field_extract
    import dsc_decode_pkg::*;
(
    // Instruction word and its extension
    input  wire logic [`WORD_W-1:0] word,
    input  wire logic [`WORD_W-1:0] ext_word,
    // Decoded fields
    output dec_t                    dec
);
    logic [7:0] opc;

    assign opc = word[`F_OPC];

    always_comb begin
        dec          = '0;
        dec.opcode   = opc;
        dec.cls      = class_t'(word[`F_CLS]);
        dec.two_word = is_two_word(opc);
        if (dec.cls == CLS_MOVD) begin
            dec.size = SZ_DWORD;
        end else if (opc[`OPB_BYTE] && (dec.cls == CLS_WORKING_REG_ZERO ||
                     dec.cls == CLS_FILE || dec.cls == CLS_LIT)) begin
            dec.size = SZ_BYTE;
        end else begin
            dec.size = SZ_WORD;
        end
        unique case (dec.cls)
            CLS_WORKING_REG_ZERO: begin
                dec.base_operand_reg   = word[`F_BASE];
                dec.src_mode           = word[`F_SMODE];
                dec.source_operand_reg = word[`F_SREG];
                dec.dst_mode           = word[`F_DMODE];
                dec.dest_operand_reg   = word[`F_DREG];
                dec.mcu_flags          = `MCU_ALL;
            end
            CLS_FILE: begin
                dec.f_addr                = word[`F_FADDR];
                dec.f_to_working_reg_zero = !word[`F_FDEST];
                dec.mcu_flags             = `MCU_ALL;
            end
            CLS_BIT: begin
                dec.bit_sel      = word[`F_BITSEL];
                dec.bit_indirect = opc[`OPB_INDIR];
                dec.bit_on_file  = opc[`OPB_FILE];
                dec.mcu_flags    = `MCU_Z;
                if (opc[`OPB_FILE]) begin
                    dec.f_addr = 13'(word[`F_BITF]);
                end else begin
                    dec.source_operand_reg = word[`F_BITREG];
                    dec.src_mode           = word[`F_BITMODE];
                end
                if (opc[`OPB_INDIR]) begin
                    dec.base_operand_reg = word[`F_BASE];
                end
            end
            CLS_LIT: begin
                dec.dest_operand_reg = word[`F_DREG];
                dec.mcu_flags        = `MCU_ALL;
                if (opc[`OPB_SIGNED]) begin
                    dec.lit = 16'($signed(word[`F_LIT]));
                end else begin
                    dec.lit = 16'(word[`F_LIT]);
                    dec.errs[`E_LIT] = opc[`OPB_BYTE] &&
                        (word[`F_LIT] > `BYTE_LIT_MAX);
                end
            end
            CLS_MAC: begin
                dec.acc_b      = word[`F_ACC];
                dec.mult_pair  = word[`F_MPAIR];
                dec.x_prefetch = word[`F_XPF];
                dec.y_prefetch = word[`F_YPF];
                dec.wb_mode    = word[`F_WB];
                dec.errs[`E_WB] = (word[`F_WB] == `WB_RSVD);
                dec.dsp_flags  = `DSP_ALL;
            end
            CLS_DSP: begin
                dec.acc_b              = word[`F_ACC];
                dec.source_operand_reg = word[`F_SREG];
                dec.src_mode           = word[`F_SMODE];
                dec.dsp_flags          = `DSP_ALL;
            end
            CLS_MOVD: begin
                dec.source_operand_reg = word[`F_SREG];
                dec.dest_operand_reg   = word[`F_DREG];
            end
            CLS_CTRL: begin
                if (dec.two_word) begin
                    dec.prog_addr = {ext_word[`F_EXTADDR],
                                     word[`F_ADDRHI], 1'b0};
                    dec.errs[`E_ADDR] = word[0];
                    dec.errs[`E_EXT] =
                        ext_word[`F_OPC] != `EXT_HI_ZERO;
                end
            end
        endcase
    end
endmodule // dsc_field_extract

// *** pm_model.sv ***
`timescale 1ns/1ns
module pm_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Loading side
    input  wire logic        push,
    input  wire logic [23:0] push_word,
    // Program word stream
    input  wire logic        pm_ready,
    output logic             pm_valid,
    output logic [23:0]      pm_word
);
    logic [23:0] mem_ff [8];
    logic [2:0]  wr_ff;
    logic [2:0]  rd_ff;
    logic [23:0] last_ff;

    // Idle word is the inverse of the last one, never a stale copy
    assign pm_valid = wr_ff != rd_ff;
    assign pm_word  = pm_valid ? mem_ff[rd_ff] : ~last_ff;

    always_ff @(posedge pclk) begin
        if (push) begin
            mem_ff[wr_ff] <= push_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ff   <= 3'h0;
            rd_ff   <= 3'h0;
            last_ff <= 24'h00_0000;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 3'h1;
            end
            if (pm_valid && pm_ready) begin
                rd_ff   <= rd_ff + 3'h1;
                last_ff <= pm_word;
            end
        end
    end
endmodule // pm_model

// *** tb_dsc_instruction_decode_timing.sv ***
`timescale 1ns/1ns
module tb_dsc_instruction_decode_timing;
    import dsc_decode_pkg::*;
    typedef struct packed {
        logic [1:0] n; logic cond; logic [23:0] a, b, c; logic [1:0] cyc;
    } row_t;
    logic pclk, presetn, pm_valid, pm_ready, cond_true, dec_valid;
    logic nop_slot, pready, pslverr, push, err;
    logic [31:0] prdata, rd;
    logic [23:0] pm_word, push_word;
    logic [1:0]  dec_cycles;
    apb_req_t    apb_req;
    dec_t        dec_q;
    int          error_cnt, total_checks;
    // Words, cond, first, second, third word, expected cycles
    row_t rows[17] = '{
        '{2'h1, 1'b0, 24'h00_0000, 24'h0, 24'h0, 2'h1},
        '{2'h1, 1'b0, 24'h01_0000, 24'h0, 24'h0, 2'h2},
        '{2'h1, 1'b0, 24'h03_0000, 24'h0, 24'h0, 2'h3},
        '{2'h1, 1'b0, 24'h05_0000, 24'h0, 24'h0, 2'h2},
        '{2'h1, 1'b0, 24'h06_0000, 24'h0, 24'h0, 2'h2},
        '{2'h1, 1'b0, 24'h07_0000, 24'h0, 24'h0, 2'h2},
        '{2'h1, 1'b0, 24'h09_0000, 24'h0, 24'h0, 2'h2},
        '{2'h1, 1'b0, 24'h0A_0000, 24'h0, 24'h0, 2'h3},
        '{2'h1, 1'b0, 24'h0B_0000, 24'h0, 24'h0, 2'h3},
        '{2'h1, 1'b0, 24'h0D_0000, 24'h0, 24'h0, 2'h1},
        '{2'h1, 1'b1, 24'h0D_0000, 24'h0, 24'h0, 2'h2},
        '{2'h2, 1'b0, 24'h02_0000, 24'h00_0001, 24'h0, 2'h2},
        '{2'h2, 1'b0, 24'h08_0000, 24'h00_0003, 24'h0, 2'h2},
        '{2'h1, 1'b0, 24'hE0_0000, 24'h0, 24'h0, 2'h2},
        '{2'h2, 1'b1, 24'h0C_0000, 24'h20_0000, 24'h0, 2'h2},
        '{2'h3, 1'b1, 24'h0C_0000, 24'h04_0000, 24'h00_0000, 2'h3},
        '{2'h1, 1'b0, 24'h00_0123, 24'h0, 24'h0, 2'h1}
    };

    dsc_instruction_decode_timing u_dsc_instruction_decode_timing (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pm_valid(pm_valid),
        .pm_word(pm_word), .pm_ready(pm_ready), .cond_true(cond_true),
        .dec_valid(dec_valid), .dec_q(dec_q), .dec_cycles(dec_cycles),
        .nop_slot(nop_slot)
    );
    pm_model u_pm_model (
        .pclk(pclk), .presetn(presetn), .push(push), .push_word(push_word),
        .pm_ready(pm_ready), .pm_valid(pm_valid), .pm_word(pm_word)
    );

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            error_cnt++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
        @(posedge pclk);
    endtask

    task automatic run(input row_t r);
        int k, nops;
        cond_true <= r.cond;
        for (k = 0; k < r.n; k++) begin
            push      <= 1'b1;
            push_word <= (k == 0) ? r.a : (k == 1) ? r.b : r.c;
            @(posedge pclk);
        end
        push <= 1'b0;
        k = 0;
        while (dec_valid !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 20) begin
            error_cnt++;
            wrap_up();
        end
        nops = (nop_slot === 1'b1);
        repeat (3) begin
            @(posedge pclk);
            nops += (nop_slot === 1'b1);
        end
        chk("opcode", dec_q.opcode, r.a[23:16]);
        chk("cycles", dec_cycles, r.cyc);
        chk("two_word", dec_q.two_word,
            r.a[23:16] inside {8'h02, 8'h04, 8'h08});
        chk("nop_cycles", nops, r.cyc - r.n);
    endtask

    task automatic one(input logic [23:0] w);
        run('{2'h1, 1'b0, w, 24'h00_0000, 24'h00_0000, 2'h1});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        apb_req = '0;
        push = 1'b0;
        push_word = 24'h00_0000;
        cond_true = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        repeat (3) @(posedge pclk);
        chk("rst_valid", dec_valid, 32'h0);
        chk("rst_ready", pm_ready, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        chk("status_rst", rd, 32'h0);
        apb(1'b1, 8'h00, 32'h0000_0001);
        foreach (rows[i]) begin
            run(rows[i]);
            $display("row %0d done", i);
        end
        apb(1'b0, 8'h08, 32'h0);
        chk("dispatched", rd, 32'h0000_0011);
        apb(1'b0, 8'h0C, 32'h0);
        chk("cycle_sum", rd, 32'h0000_0023);
        one(24'h20_A94B);
        chk("base", dec_q.base_operand_reg, 4'hA);
        chk("src", dec_q.source_operand_reg, 4'h5);
        chk("dst", dec_q.dest_operand_reg, 4'hB);
        chk("size", dec_q.size, SZ_WORD);
        one(24'h40_3FFF);
        chk("faddr", dec_q.f_addr, 13'h1FFF);
        chk("fdest", dec_q.f_to_working_reg_zero, 1'b0);
        one(24'h61_ABCF);
        chk("bitsel", dec_q.bit_sel, 4'hF);
        chk("bitfile", dec_q.bit_on_file, 1'b1);
        one(24'h82_2000);
        chk("slit", dec_q.lit, 16'hFE00);
        one(24'hA0_8002);
        chk("acc", dec_q.acc_b, 1'b1);
        chk("wb", dec_q.wb_mode, 2'h2);
        one(24'h81_12C0);
        apb(1'b0, 8'h10, 32'h0);
        chk("byte_lit_err", rd[0], 1'b1);
        run('{2'h2, 1'b0, 24'h04_1234, 24'h00_0005, 24'h00_0000, 2'h2});
        chk("paddr", dec_q.prog_addr, 23'h05_1234);
        run('{2'h2, 1'b0, 24'h02_0001, 24'h01_0000, 24'h00_0000, 2'h2});
        one(24'hA0_0003);
        apb(1'b0, 8'h10, 32'h0);
        chk("err_all", rd, 32'h0000_000F);
        apb(1'b1, 8'h10, 32'h0000_000F);
        apb(1'b0, 8'h10, 32'h0);
        chk("err_w1c", rd, 32'h0);
        $display("field tests done");
        apb(1'b1, 8'h00, 32'h0000_0003);
        apb(1'b0, 8'h08, 32'h0);
        chk("cnt_clr", rd, 32'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("rst2_valid", dec_valid, 32'h0);
        chk("rst2_ready", pm_ready, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("rst2_ctrl", rd, 32'h0);
        apb(1'b1, 8'h00, 32'h0000_0001);
        one(24'h0D_0000);
        $display("reset tests done");
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
        $display("bus tests done");
        wrap_up();
    end
endmodule // tb_dsc_instruction_decode_timing
